//--- hw/osc_defines.vh
// oscillator select control: register offsets, field positions, codes and timing counts
// assumes inclusion by bare name from the design files
`ifndef OSC_DEFINES_VH
`define OSC_DEFINES_VH

// register map
`define OSC_ADDR_W        4
`define OSC_CTRL_ADDR     4'h0
`define OSC_UNLOCK_ADDR   4'h4
`define OSC_STATUS_ADDR   4'h8

// unlock keys, written in order to the unlock register
`define OSC_KEY1          32'hAA996655
`define OSC_KEY2          32'h556699AA

// control register fields
`define OSC_DIV_HI        26
`define OSC_DIV_LO        24
`define OSC_ACT_HI        14
`define OSC_ACT_LO        12
`define OSC_REQ_HI        10
`define OSC_REQ_LO        8
`define OSC_LOCK_BIT      7
`define OSC_SLEEP_BIT     4
`define OSC_FAIL_BIT      3
`define OSC_SEC_BIT       1
`define OSC_SWEN_BIT      0

// status register fields
`define OSC_ST_UNLOCK_BIT 0
`define OSC_ST_BUSY_BIT   1

// reset values
`define OSC_DIV_RST       3'h0

// source codes
`define OSC_SRC_FAST_RC_DIVIDER    3'h0
`define OSC_SRC_PLL       3'h1
`define OSC_SRC_PRIMARY   3'h2
`define OSC_SRC_RSVD      3'h3
`define OSC_SRC_SECOND    3'h4
`define OSC_SRC_LOW_POWER_RC      3'h5
`define OSC_SRC_RSVD6     3'h6
`define OSC_SRC_RSVD7     3'h7

// divider codes and divisor widths
`define OSC_DIV_CODE_MAX  3'h7
`define OSC_DIV_CNT_W     8
`define OSC_DIV_CNT_ZERO  8'h00

// switch settle time in ns, and its cycle count at 125 MHz
`define OSC_SWITCH_NS     200
`define OSC_CLK_NS        8
`define OSC_SWITCH_CYC    ((`OSC_SWITCH_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
`define OSC_SW_CNT_W      8

`endif

//--- hw/osc_frc_divider.v
// fast rc divider: turns the raw fast rc tick into a divided one-cycle enable
// assumes frc_tick_i is a one-cycle pulse synchronous to clock_i
`timescale 1ns/1ps
`include "osc_defines.vh"

module osc_frc_divider (
	// clock and reset
	input  wire       clock_i,
	input  wire       sys_rst_i,
	// control
	input  wire [2:0] div_code_i,
	input  wire       frc_tick_i,
	// divided enable
	output reg        div_tick_o
);

	reg  [`OSC_DIV_CNT_W-1:0] cnt_q;
	reg  [`OSC_DIV_CNT_W-1:0] limit;

	// terminal count per code: 0,1,3,7,15,31,63,255 (divide by 1,2,4,8,16,32,64,256)
	always @* begin
		case (div_code_i)
			3'h0:    limit = 8'h00;
			3'h1:    limit = 8'h01;
			3'h2:    limit = 8'h03;
			3'h3:    limit = 8'h07;
			3'h4:    limit = 8'h0F;
			3'h5:    limit = 8'h1F;
			3'h6:    limit = 8'h3F;
			default: limit = 8'hFF;
		endcase
	end

	// count raw ticks, emit one tick at terminal count
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q      <= `OSC_DIV_CNT_ZERO;
			div_tick_o <= 1'b0;
		end else begin
			div_tick_o <= 1'b0;
			if (frc_tick_i) begin
				if (cnt_q >= limit) begin
					cnt_q      <= `OSC_DIV_CNT_ZERO;
					div_tick_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 8'h01;
				end
			end
		end
	end

endmodule

//--- hw/osc_select_ctrl.v
// oscillator select control: control register, unlock gate, switch sequencer, divider
// assumes a plain register port and configuration straps stable around reset release
// Function
// - divide fast rc by 1,2,4,8,16,32,64,256 per field bits 26:24
// - divider field resets to zero, fast rc undivided
// - read-only active source field at bits 14:12 shows current source
// - codes 110 and 111 select divided fast rc
// - writable requested source field at bits 10:8, same encoding
// - requested source loads from initial source configuration at reset
// - active source loads from initial source configuration at reset
// - lock bit 7 set freezes source and pll selections
// - wait enters sleep when bit 4 set, else idle
// - hardware sets clock fail bit 3 on monitor failure
// - bit 1 enables secondary oscillator
// - secondary enable loads from its configuration at reset
// - writing switch enable starts switch; hardware clears it when done
// - switch enable resets to two-speed startup configuration value
// - control writes ignored unless unlock sequence completed
// - unimplemented bits read as zero
`timescale 1ns/1ps
`include "osc_defines.vh"

module osc_select_ctrl #(
	parameter SWITCH_CYC = `OSC_SWITCH_CYC
) (
	// clock and reset
	input  wire                   clock_i,
	input  wire                   sys_rst_i,
	// register port
	input  wire [`OSC_ADDR_W-1:0] reg_addr_i,
	input  wire [31:0]            reg_wdata_i,
	input  wire                   reg_wr_i,
	input  wire                   reg_rd_i,
	output reg  [31:0]            reg_rdata_o,
	// configuration straps
	input  wire [2:0]             initial_source_cfg_i,
	input  wire                   two_speed_startup_cfg_i,
	input  wire                   secondary_osc_cfg_i,
	// system events
	input  wire                   fail_safe_monitor_fail_i,
	input  wire                   wait_exec_i,
	input  wire                   frc_tick_i,
	// clock controls
	output reg  [2:0]             active_source_o,
	output reg                    secondary_osc_enable_o,
	output reg                    frc_div_tick_o,
	output reg                    sleep_enter_o,
	output reg                    idle_enter_o
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	localparam ST_IDLE   = 2'h0;
	localparam ST_SETTLE = 2'h1;
	localparam ST_DONE   = 2'h2;

	reg  [2:0]                div_q;
	reg  [2:0]                act_q;
	reg  [2:0]                req_q;
	reg                       lock_q;
	reg                       sleep_q;
	reg                       fail_q;
	reg                       sec_q;
	reg                       swen_q;
	reg  [1:0]                key_q;
	reg  [1:0]                st_q;
	reg  [`OSC_SW_CNT_W-1:0]  cnt_q;
	reg                       strap_q;
	wire                      div_tick;
	wire                      wr_ctrl;
	wire                      wr_unlk;
	wire                      unlocked;
	wire                      switch_done;
	reg  [31:0]               ctrl_word;

	assign unlocked    = (key_q == 2'h2);
	assign wr_ctrl     = reg_wr_i && (reg_addr_i == `OSC_CTRL_ADDR) && unlocked;
	assign wr_unlk     = reg_wr_i && (reg_addr_i == `OSC_UNLOCK_ADDR);
	assign switch_done = (st_q == ST_DONE);

	////////////////////////////////////////////////////////////////////////////////
	// unlock sequence: key1 then key2 opens one control write

	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			key_q <= 2'h0;
		end else if (wr_unlk) begin
			if (reg_wdata_i == `OSC_KEY1)
				key_q <= 2'h1;
			else if (reg_wdata_i == `OSC_KEY2 && key_q == 2'h1)
				key_q <= 2'h2;
			else
				key_q <= 2'h0;
		end else if (wr_ctrl) begin
			key_q <= 2'h0; // one write per unlock
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register fields

	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_q   <= `OSC_DIV_RST;
			lock_q  <= 1'b0;
			sleep_q <= 1'b0;
			fail_q  <= 1'b0;
			strap_q <= 1'b1;
			act_q   <= `OSC_SRC_FAST_RC_DIVIDER;
			req_q   <= `OSC_SRC_FAST_RC_DIVIDER;
			sec_q   <= 1'b0;
			swen_q  <= 1'b0;
		end else begin
			strap_q <= 1'b0;
			if (strap_q) begin
				// straps caught on the first edge after release
				act_q  <= initial_source_cfg_i;
				req_q  <= initial_source_cfg_i;
				sec_q  <= secondary_osc_cfg_i;
				swen_q <= two_speed_startup_cfg_i;
			end else begin
				if (wr_ctrl) begin
					div_q   <= reg_wdata_i[`OSC_DIV_HI:`OSC_DIV_LO];
					sleep_q <= reg_wdata_i[`OSC_SLEEP_BIT];
					sec_q   <= reg_wdata_i[`OSC_SEC_BIT];
					if (!lock_q) begin
						lock_q <= reg_wdata_i[`OSC_LOCK_BIT];
						req_q  <= reg_wdata_i[`OSC_REQ_HI:`OSC_REQ_LO];
					end
				end
				// completion clears enable; a start written while enable is still set is ignored
				if (wr_ctrl && !lock_q && reg_wdata_i[`OSC_SWEN_BIT] && !swen_q)
					swen_q <= 1'b1;
				else if (switch_done)
					swen_q <= 1'b0;
				if (switch_done)
					act_q <= req_q;
			end
			// hardware set wins over a software clear, strap cycle included
			if (fail_safe_monitor_fail_i)
				fail_q <= 1'b1;
			else if (wr_ctrl && !strap_q)
				fail_q <= reg_wdata_i[`OSC_FAIL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// switch sequencer: settle then commit

	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q  <= ST_IDLE;
			cnt_q <= {`OSC_SW_CNT_W{1'b0}};
		end else begin
			case (st_q)
				ST_IDLE: begin
					cnt_q <= {`OSC_SW_CNT_W{1'b0}};
					if (swen_q && !strap_q)
						st_q <= ST_SETTLE;
				end
				ST_SETTLE: begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q >= SWITCH_CYC[`OSC_SW_CNT_W-1:0] - 8'h01)
						st_q <= ST_DONE;
				end
				ST_DONE: begin
					st_q <= ST_IDLE;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// divider

	osc_frc_divider osc_frc_divider_i (
		.clock_i    (clock_i),
		.sys_rst_i  (sys_rst_i),
		.div_code_i (div_q),
		.frc_tick_i (frc_tick_i),
		.div_tick_o (div_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// read data and outputs

	always @* begin
		ctrl_word                            = 32'h00000000;
		ctrl_word[`OSC_DIV_HI:`OSC_DIV_LO]   = div_q;
		ctrl_word[`OSC_ACT_HI:`OSC_ACT_LO]   = act_q;
		ctrl_word[`OSC_REQ_HI:`OSC_REQ_LO]   = req_q;
		ctrl_word[`OSC_LOCK_BIT]             = lock_q;
		ctrl_word[`OSC_SLEEP_BIT]            = sleep_q;
		ctrl_word[`OSC_FAIL_BIT]             = fail_q;
		ctrl_word[`OSC_SEC_BIT]              = sec_q;
		ctrl_word[`OSC_SWEN_BIT]             = swen_q;
	end

	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o            <= 32'h00000000;
			active_source_o        <= `OSC_SRC_FAST_RC_DIVIDER;
			secondary_osc_enable_o <= 1'b0;
			frc_div_tick_o         <= 1'b0;
			sleep_enter_o          <= 1'b0;
			idle_enter_o           <= 1'b0;
		end else begin
			reg_rdata_o <= 32'h00000000;
			if (reg_rd_i) begin
				case (reg_addr_i)
					`OSC_CTRL_ADDR:   reg_rdata_o <= ctrl_word;
					`OSC_STATUS_ADDR: reg_rdata_o <= {30'h0, (st_q != ST_IDLE), unlocked};
					default:          reg_rdata_o <= 32'h00000000;
				endcase
			end
			// reserved codes 6 and 7 fall back to divided fast rc; reserved code 3 passes through
			if (act_q == `OSC_SRC_RSVD6 || act_q == `OSC_SRC_RSVD7)
				active_source_o <= `OSC_SRC_FAST_RC_DIVIDER;
			else
				active_source_o <= act_q;
			secondary_osc_enable_o <= sec_q;
			frc_div_tick_o         <= div_tick;
			sleep_enter_o          <= wait_exec_i && sleep_q;
			idle_enter_o           <= wait_exec_i && !sleep_q;
		end
	end

endmodule

//--- sim/osc_sel_monitor.sv
// checker for the oscillator select control register port and event outputs
// assumes a single clock domain and binding onto osc_select_ctrl
`timescale 1ns/1ps
`include "osc_defines.vh"

module osc_sel_monitor (
	// clock and reset
	input wire                   clock_i,
	input wire                   sys_rst_i,
	// register port
	input wire [`OSC_ADDR_W-1:0] reg_addr_i,
	input wire                   reg_rd_i,
	input wire [31:0]            reg_rdata_o,
	// events and outputs
	input wire                   fail_safe_monitor_fail_i,
	input wire                   wait_exec_i,
	input wire                   frc_tick_i,
	input wire [2:0]             active_source_o,
	input wire                   frc_div_tick_o,
	input wire                   sleep_enter_o,
	input wire                   idle_enter_o
);
////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	// decoded control read strobe and mapped address match
	wire rd_ctl = reg_rd_i && reg_addr_i == `OSC_CTRL_ADDR;
	wire mapped = reg_addr_i == `OSC_CTRL_ADDR || reg_addr_i == `OSC_UNLOCK_ADDR
		|| reg_addr_i == `OSC_STATUS_ADDR;
	// monitor failure followed by a control read
	sequence fail_then_read;
		fail_safe_monitor_fail_i ##1 rd_ctl;
	endsequence
////////////////////////////////////////////////////////////////////////////////
	rd_idle_zero_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	unmapped_zero_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 32'h0)
		else $error("unmapped read returned data");
	unimpl_zero_a:
		assert property (rd_ctl |=> (reg_rdata_o & 32'hF8FF8864) == 32'h0)
		else $error("unimplemented control bits read nonzero");
	wait_one_a: assert property (wait_exec_i |=> sleep_enter_o ^ idle_enter_o)
		else $error("wait did not give exactly one of sleep or idle");
	wait_quiet_a:
		assert property (!wait_exec_i |=> !sleep_enter_o && !idle_enter_o)
		else $error("sleep or idle without a wait");
	src_code_a: assert property (active_source_o < 3'h6)
		else $error("reserved source code driven");
	fail_kept_a: assert property (fail_then_read |=> reg_rdata_o[`OSC_FAIL_BIT])
		else $error("clock fail bit not set after monitor failure");
	div_cause_a: assert property (frc_div_tick_o |-> $past(frc_tick_i, 2))
		else $error("divided tick without a raw tick");
endmodule

bind osc_select_ctrl osc_sel_monitor osc_sel_monitor_i (.clock_i, .sys_rst_i,
	.reg_addr_i, .reg_rd_i, .reg_rdata_o, .fail_safe_monitor_fail_i, .wait_exec_i,
	.frc_tick_i, .active_source_o, .frc_div_tick_o, .sleep_enter_o, .idle_enter_o);

//--- sim/osc_select_ctrl_test.sv
// testbench: register sequences for oscillator select control
// assumes the checker is bound separately and a short switch settle time
`timescale 1ns/1ps
`include "osc_defines.vh"

module osc_select_ctrl_test;
	reg         clock_i = 1'h0;
	reg         sys_rst_i = 1'h1;
	reg  [3:0]  reg_addr_i = 4'h0;
	reg  [31:0] reg_wdata_i = 32'h0;
	reg         reg_wr_i = 1'h0, reg_rd_i = 1'h0, wait_exec_i = 1'h0, frc_tick_i = 1'h0;
	reg  [2:0]  initial_source_cfg_i = 3'h2;
	reg         two_speed_startup_cfg_i = 1'h0, secondary_osc_cfg_i = 1'h1;
	reg         fail_safe_monitor_fail_i = 1'h0;
	wire [31:0] reg_rdata_o;
	wire [2:0]  active_source_o;
	wire        secondary_osc_enable_o, frc_div_tick_o, sleep_enter_o, idle_enter_o;
	reg  [31:0] d;
	integer     error_cnt = 0, compares = 0, cyc = 0, i, n, m;
////////////////////////////////////////////////////////////////////////////////
	osc_select_ctrl #(.SWITCH_CYC(2)) osc_select_ctrl_i (.clock_i, .sys_rst_i,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.initial_source_cfg_i, .two_speed_startup_cfg_i, .secondary_osc_cfg_i,
		.fail_safe_monitor_fail_i, .wait_exec_i, .frc_tick_i, .active_source_o,
		.secondary_osc_enable_o, .frc_div_tick_o, .sleep_enter_o, .idle_enter_o);
	// clock and hang guard
	always #4 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			conclude;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	task chk(input [31:0] s, input [31:0] e); begin
		compares = compares + 1;
		if (s !== e) begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	end endtask
	task w(input [3:0] a, input [31:0] v); begin
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'h1;
		@(posedge clock_i);
		reg_wr_i <= 1'h0;
	end endtask
	task r(input [3:0] a); begin
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'h1;
		@(posedge clock_i);
		reg_rd_i <= 1'h0;
		#1 d = reg_rdata_o;
	end endtask
	// unlock then one control write
	task ctl(input [31:0] v); begin
		w(`OSC_UNLOCK_ADDR, `OSC_KEY1);
		w(`OSC_UNLOCK_ADDR, `OSC_KEY2);
		w(`OSC_CTRL_ADDR, v);
	end endtask
	// poll status until the switch is no longer busy
	task sw; begin
		repeat (2) @(posedge clock_i);
		n = 0;
		d = 32'h2;
		while (d[1] !== 1'h0 && n < 40) begin
			r(`OSC_STATUS_ADDR);
			n = n + 1;
		end
		chk(d[1], 1'h0);
	end endtask
	task pw(input [1:0] e); begin
		@(posedge clock_i);
		wait_exec_i <= 1'h1;
		@(posedge clock_i);
		wait_exec_i <= 1'h0;
		#1 chk({sleep_enter_o, idle_enter_o}, e);
	end endtask
	task rst(input [2:0] s, input t, input c); begin
		@(posedge clock_i);
		sys_rst_i <= 1'h1;
		initial_source_cfg_i <= s;
		two_speed_startup_cfg_i <= t;
		secondary_osc_cfg_i <= c;
		repeat (4) @(posedge clock_i);
		sys_rst_i <= 1'h0;
		repeat (2) @(posedge clock_i);
	end endtask
	task conclude; begin
		$display("mismatches %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end endtask
////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst(3'h2, 1'h0, 1'h1);
		r(`OSC_CTRL_ADDR); chk(d, 32'h00002202);
		chk(active_source_o, 3'h2);
		w(`OSC_CTRL_ADDR, 32'h10);
		r(`OSC_CTRL_ADDR); chk(d, 32'h00002202);
		r(4'hC); chk(d, 32'h0);
		ctl(32'hFFFFFD75);
		w(`OSC_CTRL_ADDR, 32'h0);
		#1 chk(secondary_osc_enable_o, 1'h0);
		sw;
		r(`OSC_CTRL_ADDR); chk(d, 32'h07005510);
		chk(active_source_o, 3'h5);
		pw(2'h2);
		for (i = 0; i < 8; i = i + 1) begin
			ctl({5'h0, i[2:0], 24'h000500});
			m = (i == 7) ? 256 : (1 << i);
			n = 0;
			frc_tick_i <= 1'h1;
			repeat (4 * m + 3) begin
				@(posedge clock_i);
				#1 n = n + (frc_div_tick_o === 1'h1);
			end
			@(posedge clock_i);
			frc_tick_i <= 1'h0;
			repeat (3) @(posedge clock_i);
			chk(n >= 3 && n <= 6, 1);
		end
		pw(2'h1);
		ctl(32'h00000601);
		sw;
		chk(active_source_o, 3'h0);
		@(posedge clock_i);
		fail_safe_monitor_fail_i <= 1'h1;
		r(`OSC_CTRL_ADDR); chk(d[3], 1'h1);
		@(posedge clock_i);
		fail_safe_monitor_fail_i <= 1'h0;
		ctl(32'h07000600);
		r(`OSC_CTRL_ADDR); chk(d[3], 1'h0);
		ctl(32'h07000690);
		ctl(32'h03000101);
		r(`OSC_CTRL_ADDR); chk({d[26:24], d[10:7], d[0]}, 8'h7A);
		rst(3'h1, 1'h1, 1'h0);
		r(`OSC_CTRL_ADDR); chk({d[10:8], d[1:0]}, 5'h5);
		sw;
		r(`OSC_CTRL_ADDR); chk(d[0], 1'h0);
		chk(active_source_o, 3'h1);
		conclude;
	end
endmodule
